/* common/timer_regs.vh */
// Operation
// - Sixteen-bit down counter, internal or external clock.
// - Period is high byte above low byte.
// - Period reads back programmed value; timer-reset keeps it.
// - Command bits execute once and self-clear.
// - Command read gives 01 only if enabled and pending.
// - Resets restore default mode, source, routing, stopped.
// - Codes 0001/0010 enable/disable the interrupt.
// - Codes 0011/0100 select one-shot/re-triggerable mode.
// - Codes 0101/0110 select internal/external count clock.
// - Codes 0111/1000 route/unroute output to pin zero.
// - Codes 1001/1010/1011 start, stop, reset timer.
// - One-shot output high for N clocks, then low.
// - One-shot restart before timeout reloads full period.
// - After one-shot timeout only stop or a reset restores high output.
// - Started one-shot ignores period writes, setup commands.
// - Re-triggerable output high P, low Q, repeating.
// - Running re-triggerable ignores period writes, most commands.
// - Routed pin zero drives timer output, ignores controls.
// - Interrupt at one-shot timeout, each periodic rising edge.
// - Interrupt clears on command read or timer-reset.
// - Interrupt reported as a channel zero source.
// - Timer source code is all ones in channel zero.
`ifndef TIMER_REGS_VH
`define TIMER_REGS_VH
// =====================================================================
// Register map
`define TMR_ADDR 8'h84
`define TMR_CMD_LSB 0
`define TMR_LO_LSB 16
`define TMR_HI_LSB 24
`define TMR_BE_CMD 0
`define TMR_BE_RSVD 1
`define TMR_BE_LO 2
`define TMR_BE_HI 3
`define TMR_STATUS_PEND 8'h01
`define TMR_STATUS_NONE 8'h00
`define TMR_PERIOD_RST 8'h00
// =====================================================================
// Command codes
`define CMD_INT_EN 4'h1
`define CMD_INT_DIS 4'h2
`define CMD_ONESHOT 4'h3
`define CMD_RETRIG 4'h4
`define CMD_SRC_INT 4'h5
`define CMD_SRC_EXT 4'h6
`define CMD_ROUTE 4'h7
`define CMD_UNROUTE 4'h8
`define CMD_START 4'h9
`define CMD_STOP 4'hA
`define CMD_RESET 4'hB
// =====================================================================
// Interrupt source codes
`define INT_SRC_NONE 3'h0
`define INT_SRC_TIMER 3'h7
`endif

/* rtl/count_edge_sync.v */
`timescale 1ns/10ps
`default_nettype none
module count_edge_sync
(
  input wire clk_i,
  input wire rst_n_i,
  input wire async_i,
  output wire rise_o
);

  reg meta;
  reg stable;
  reg prev;

  // =====================================================================
  // Two-stage synchronizer; only the second stage feeds the edge detect.
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      meta <= 1'b0;
      stable <= 1'b0;
      prev <= 1'b0;
    end
    else
    begin
      meta <= async_i;
      stable <= meta;
      prev <= stable;
    end
  end

  // One-cycle pulse on each synchronized rising edge.
  assign rise_o = stable & ~prev;

endmodule
`default_nettype wire

/* rtl/timer_cmd_decode.v */
`timescale 1ns/10ps
`default_nettype none
module timer_cmd_decode
(
  input wire valid_i,
  input wire [3:0] code_i,
  output wire [15:0] onehot_o
);

  // =====================================================================
  // One-hot decode of a command code, gated by its write strobe.
  function [15:0] decode;
    input v;
    input [3:0] c;
    begin
      decode = 16'h0000;
      if (v)
      begin
        decode[c] = 1'b1;
      end
    end
  endfunction

  // Reserved codes land on bits nothing reads, so they do nothing.
  assign onehot_o = decode(valid_i, code_i);

endmodule
`default_nettype wire

/* rtl/general_timer_counter16.v */
`timescale 1ns/10ps
`default_nettype none
`include "timer_regs.vh"
module general_timer_counter16
#(
  parameter WIDTH = 16
)
(
  input wire CLOCK_I,
  input wire RST_N_I,
  input wire [7:0] REG_ADDR_I,
  input wire REG_WR_I,
  input wire REG_RD_I,
  input wire [3:0] REG_BE_I,
  input wire [31:0] REG_WDATA_I,
  output wire [31:0] REG_RDATA_O,
  output wire REG_RVALID_O,
  input wire EXT_COUNT_CLOCK_I,
  input wire PIN_LEVEL_I,
  input wire PIN_DIR_IN_I,
  input wire PIN_TRISTATE_I,
  output wire TIMER_OUT_O,
  output wire MPIO0_O,
  output wire MPIO0_OE_N_O,
  output wire INT_PENDING_O,
  output wire [2:0] INT_CODE_O
);

  // =====================================================================
  // Counter states.
  localparam ST_STOP = 2'b00;
  localparam ST_RUN = 2'b01;
  localparam ST_DONE = 2'b10;

  // =====================================================================
  // Declarations.
  reg [1:0] state;
  reg [WIDTH-1:0] cnt;
  reg phase_low;
  reg out_level;
  reg int_en;
  reg oneshot;
  reg ext_sel;
  reg route;
  reg pend;
  reg [7:0] period_hi;
  reg [7:0] period_lo;
  reg [31:0] rdata;
  reg rvalid;
  reg pin_level;
  reg pin_oe_n;
  reg int_pending;
  reg [2:0] int_code;
  wire hit;
  wire cmd_valid;
  wire [15:0] cmd;
  wire started;
  wire cfg_ok;
  wire ext_rise;
  wire tick;
  wire [WIDTH-1:0] period;
  wire [WIDTH-1:0] half_p;
  wire [WIDTH-1:0] half_q;
  wire c_start;
  wire c_stop;
  wire c_reset;
  wire rd_clear;
  wire last_tick;
  wire timeout_evt;
  wire next_int;

  // =====================================================================
  // Register port decode.
  // Every read is answered; only the timer dword returns data, other addresses read as zero.
  assign hit = ({REG_ADDR_I[7:2], 2'b00} == `TMR_ADDR);
  assign cmd_valid = REG_WR_I & hit & REG_BE_I[`TMR_BE_CMD];
  assign rd_clear = REG_RD_I & hit & REG_BE_I[`TMR_BE_CMD];

  // Command strobes last one cycle, so nothing stays latched.
  timer_cmd_decode u_decode
  (
    .valid_i(cmd_valid),
    .code_i(REG_WDATA_I[`TMR_CMD_LSB+3:`TMR_CMD_LSB]),
    .onehot_o(cmd)
  );

  assign c_start = cmd[`CMD_START];
  assign c_stop = cmd[`CMD_STOP];
  assign c_reset = cmd[`CMD_RESET];

  // Once started, setup commands and period writes are locked out.
  assign started = (state != ST_STOP);
  assign cfg_ok = ~started;

  // =====================================================================
  // Period value and its two phases.
  assign period = {period_hi, period_lo};
  assign half_p = period >> 1;
  assign half_q = period - half_p;

  // =====================================================================
  // Count clock source.
  // The external pin is sampled into this clock domain first.
  count_edge_sync u_sync
  (
    .clk_i(CLOCK_I),
    .rst_n_i(RST_N_I),
    .async_i(EXT_COUNT_CLOCK_I),
    .rise_o(ext_rise)
  );

  // The internal source counts every system clock.
  assign tick = ext_sel ? ext_rise : 1'b1;

  // =====================================================================
  // Period bytes.
  // Hardware reset clears them; the timer-reset command does not.
  always @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
    begin
      period_hi <= `TMR_PERIOD_RST;
      period_lo <= `TMR_PERIOD_RST;
    end
    else if (REG_WR_I && hit && cfg_ok)
    begin
      if (REG_BE_I[`TMR_BE_HI])
      begin
        period_hi <= REG_WDATA_I[`TMR_HI_LSB+7:`TMR_HI_LSB];
      end
      if (REG_BE_I[`TMR_BE_LO])
      begin
        period_lo <= REG_WDATA_I[`TMR_LO_LSB+7:`TMR_LO_LSB];
      end
    end
  end

  // =====================================================================
  // Configuration flags.
  // Both resets restore the defaults; commands apply only while stopped.
  always @(posedge CLOCK_I)
  begin
    if (!RST_N_I || c_reset)
    begin
      int_en <= 1'b0;
      oneshot <= 1'b0;
      ext_sel <= 1'b0;
      route <= 1'b0;
    end
    else if (cfg_ok)
    begin
      if (cmd[`CMD_INT_EN])
      begin
        int_en <= 1'b1;
      end
      if (cmd[`CMD_INT_DIS])
      begin
        int_en <= 1'b0;
      end
      if (cmd[`CMD_ONESHOT])
      begin
        oneshot <= 1'b1;
      end
      if (cmd[`CMD_RETRIG])
      begin
        oneshot <= 1'b0;
      end
      if (cmd[`CMD_SRC_INT])
      begin
        ext_sel <= 1'b0;
      end
      if (cmd[`CMD_SRC_EXT])
      begin
        ext_sel <= 1'b1;
      end
      if (cmd[`CMD_ROUTE])
      begin
        route <= 1'b1;
      end
      if (cmd[`CMD_UNROUTE])
      begin
        route <= 1'b0;
      end
    end
  end

  // =====================================================================
  // Timeout detection.
  // The last count of a phase ends it unless a command overrides it.
  assign last_tick = (state == ST_RUN) && tick && (cnt == {{(WIDTH-1){1'b0}}, 1'b1});
  assign timeout_evt = last_tick && !c_stop && !c_reset && !(c_start && oneshot)
                       && (oneshot || phase_low);

  // =====================================================================
  // Counter state machine.
  always @(posedge CLOCK_I)
  begin
    if (!RST_N_I || c_reset)
    begin
      state <= ST_STOP;
      cnt <= {WIDTH{1'b0}};
      phase_low <= 1'b0;
      out_level <= 1'b1;
    end
    else if (c_stop)
    begin
      state <= ST_STOP;
      phase_low <= 1'b0;
      out_level <= 1'b1;
    end
    else
    begin
      case (state)
        ST_STOP:
        begin
          if (c_start)
          begin
            state <= ST_RUN;
            phase_low <= 1'b0;
            out_level <= 1'b1;
            cnt <= oneshot ? period : half_p;
          end
        end
        ST_RUN:
        begin
          if (c_start && oneshot)
          begin
            cnt <= period;
          end
          else if (last_tick)
          begin
            if (oneshot)
            begin
              state <= ST_DONE;
              out_level <= 1'b0;
            end
            else if (!phase_low)
            begin
              phase_low <= 1'b1;
              out_level <= 1'b0;
              cnt <= half_q;
            end
            else
            begin
              phase_low <= 1'b0;
              out_level <= 1'b1;
              cnt <= half_p;
            end
          end
          else if (tick)
          begin
            cnt <= cnt - {{(WIDTH-1){1'b0}}, 1'b1};
          end
        end
        ST_DONE:
        begin
          // A start here does nothing; only stop or a reset leaves this state.
          state <= ST_DONE;
        end
        default:
        begin
          state <= ST_STOP;
        end
      endcase
    end
  end

  // =====================================================================
  // Pending interrupt.
  // A timeout in the clearing cycle wins, so no event is lost.
  always @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
    begin
      pend <= 1'b0;
    end
    else
    begin
      pend <= timeout_evt | (pend & ~rd_clear & ~c_reset);
    end
  end

  // =====================================================================
  // Register read port.
  // The status byte reflects enable and pending, never the command.
  always @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
    begin
      rdata <= 32'h00000000;
      rvalid <= 1'b0;
    end
    else
    begin
      rvalid <= REG_RD_I;
      if (REG_RD_I && hit)
      begin
        rdata <= {period_hi, period_lo, 8'h00,
                  (int_en && pend) ? `TMR_STATUS_PEND : `TMR_STATUS_NONE};
      end
      else
      begin
        rdata <= 32'h00000000;
      end
    end
  end

  // =====================================================================
  // Channel zero interrupt source report.
  assign next_int = int_en & pend;

  always @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
    begin
      int_pending <= 1'b0;
      int_code <= `INT_SRC_NONE;
    end
    else
    begin
      int_pending <= next_int;
      int_code <= next_int ? `INT_SRC_TIMER : `INT_SRC_NONE;
    end
  end

  // =====================================================================
  // Pin zero mux.
  // Routing overrides the normal level, direction and tristate controls.
  always @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
    begin
      pin_level <= 1'b0;
      pin_oe_n <= 1'b1;
    end
    else if (route)
    begin
      pin_level <= out_level;
      pin_oe_n <= 1'b0;
    end
    else
    begin
      pin_level <= PIN_LEVEL_I;
      pin_oe_n <= PIN_DIR_IN_I | PIN_TRISTATE_I;
    end
  end

  // =====================================================================
  // Outputs, all from flip-flops.
  assign REG_RDATA_O = rdata;
  assign REG_RVALID_O = rvalid;
  assign TIMER_OUT_O = out_level;
  assign MPIO0_O = pin_level;
  assign MPIO0_OE_N_O = pin_oe_n;
  assign INT_PENDING_O = int_pending;
  assign INT_CODE_O = int_code;

endmodule
`default_nettype wire

/* verif/general_timer_counter16_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
// =====================================================================
// Port checker for the timer block.
module timer_port_checker
(
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [3:0] REG_BE_I,
  input wire logic [31:0] REG_WDATA_I,
  input wire logic PIN_DIR_IN_I,
  input wire logic PIN_TRISTATE_I,
  input wire logic [31:0] REG_RDATA_O,
  input wire logic REG_RVALID_O,
  input wire logic TIMER_OUT_O,
  input wire logic MPIO0_O,
  input wire logic MPIO0_OE_N_O,
  input wire logic INT_PENDING_O,
  input wire logic [2:0] INT_CODE_O
);
  default clocking @(posedge CLOCK_I);
  endclocking
  default disable iff (!RST_N_I);
  // Command-lane access to the timer dword.
  wire hit = REG_ADDR_I[7:2] == 6'h21 && REG_BE_I[0];
  wire stop_cmd = REG_WR_I && hit && REG_WDATA_I[3:0] == 4'hA;
  wire rst_cmd = REG_WR_I && hit && REG_WDATA_I[3:0] == 4'hB;
  property p_rd_answer;
    REG_RD_I |=> REG_RVALID_O;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_idle_zero;
    !REG_RD_I |=> !REG_RVALID_O && REG_RDATA_O == 32'h0;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("stray read data");
  property p_cmd_clear;
    REG_RVALID_O |-> REG_RDATA_O[15:1] == 15'h0;
  endproperty
  a_cmd_clear: assert property (p_cmd_clear) else $error("command bits read back");
  property p_code;
    INT_CODE_O == (INT_PENDING_O ? 3'h7 : 3'h0);
  endproperty
  a_code: assert property (p_code) else $error("bad source code");
  property p_stop;
    stop_cmd |=> TIMER_OUT_O;
  endproperty
  a_stop: assert property (p_stop) else $error("output low after stop");
  property p_reset_cmd;
    rst_cmd |=> TIMER_OUT_O ##1
      ((MPIO0_OE_N_O == $past(PIN_DIR_IN_I || PIN_TRISTATE_I)) && !INT_PENDING_O);
  endproperty
  a_reset_cmd: assert property (p_reset_cmd) else $error("timer reset incomplete");
  property p_rd_clear;
    REG_RD_I && hit |=> ##1 (!INT_PENDING_O || TIMER_OUT_O != $past(TIMER_OUT_O, 2));
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("read kept interrupt");
  property p_pin_follow;
    !MPIO0_OE_N_O && $past(!MPIO0_OE_N_O) |-> MPIO0_O == $past(TIMER_OUT_O);
  endproperty
  a_pin_follow: assert property (p_pin_follow) else $error("pin not following");
  c_fall: cover property ($fell(TIMER_OUT_O));
  c_int: cover property ($rose(INT_PENDING_O));
  c_route: cover property ($fell(MPIO0_OE_N_O));
endmodule
bind general_timer_counter16 timer_port_checker chk_u
(
  .CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .REG_ADDR_I(REG_ADDR_I), .REG_WR_I(REG_WR_I),
  .REG_RD_I(REG_RD_I), .REG_BE_I(REG_BE_I), .REG_WDATA_I(REG_WDATA_I),
  .PIN_DIR_IN_I(PIN_DIR_IN_I), .PIN_TRISTATE_I(PIN_TRISTATE_I),
  .REG_RDATA_O(REG_RDATA_O), .REG_RVALID_O(REG_RVALID_O), .TIMER_OUT_O(TIMER_OUT_O),
  .MPIO0_O(MPIO0_O), .MPIO0_OE_N_O(MPIO0_OE_N_O), .INT_PENDING_O(INT_PENDING_O),
  .INT_CODE_O(INT_CODE_O)
);
`default_nettype wire

/* verif/general_timer_counter16_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module general_timer_counter16_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h84;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] be = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic ext = 1'b0;
  logic ext_run = 1'b0;
  logic pin_tri = 1'b0;
  wire logic [31:0] rdata;
  wire logic rvalid, tout, pin, pin_oe_n, irq;
  wire logic [2:0] code;
  int fails = 0;
  int checked = 0;
  // =====================================================================
  // Device under test; the normal pin controls ask for an input pin.
  general_timer_counter16 dut
  (
    .CLOCK_I(clk), .RST_N_I(rst_n), .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_RD_I(rd),
    .REG_BE_I(be), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
    .EXT_COUNT_CLOCK_I(ext), .PIN_LEVEL_I(1'b0), .PIN_DIR_IN_I(1'b1),
    .PIN_TRISTATE_I(pin_tri), .TIMER_OUT_O(tout), .MPIO0_O(pin), .MPIO0_OE_N_O(pin_oe_n),
    .INT_PENDING_O(irq), .INT_CODE_O(code)
  );
  // System clock and a slow external count clock, idle low when stopped.
  initial forever #5 clk = ~clk;
  initial forever #40 ext = ext_run ? ~ext : 1'b0;
  // =====================================================================
  // Shared tasks.
  task automatic test_done;
    $display("Checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [3:0] lanes, input logic [31:0] data);
    @(posedge clk);
    #1;
    wr = 1'b1;
    be = lanes;
    wdata = data;
    @(posedge clk);
    #1;
    wr = 1'b0;
  endtask
  task automatic cmd(input logic [3:0] c);
    wr_reg(4'h1, {28'h0, c});
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    #1;
    rd = 1'b1;
    be = 4'hF;
    addr = a;
    @(posedge clk);
    #1;
    rd = 1'b0;
    addr = 8'h84;
    chk("rvalid", {31'h0, rvalid}, 32'h1);
    d = rdata;
  endtask
  // Counts clock edges until the timer output reaches the given level.
  task automatic wait_lvl(input logic lvl, output int k);
    k = 0;
    while (tout !== lvl && k < 100)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    if (tout !== lvl)
    begin
      fails++;
      test_done;
    end
  endtask
  // =====================================================================
  // Scenarios.
  task automatic t_reset;
    logic [31:0] d;
    rd_reg(8'h84, d);
    chk("dword", d, 32'h0);
    rd_reg(8'h88, d);
    chk("unmapped", d, 32'h0);
    chk("idle pins", {tout, pin_oe_n, irq, code}, 32'h30);
    wr_reg(4'h8, 32'hAB00_0000);
    wr_reg(4'h4, 32'h0006_0000);
    rd_reg(8'h84, d);
    chk("period", d, 32'hAB06_0000);
    wr_reg(4'h8, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_oneshot;
    logic [31:0] d;
    int k;
    cmd(4'h1);
    cmd(4'h3);
    cmd(4'h9);
    repeat (3) @(posedge clk);
    cmd(4'h9);
    wait_lvl(1'b0, k);
    chk("shot len", k, 6);
    @(posedge clk);
    #1;
    chk("irq code", {irq, code}, 32'hF);
    wr_reg(4'hC, 32'h0002_0000);
    cmd(4'h2);
    cmd(4'h9);
    chk("done low", tout, 1'b0);
    rd_reg(8'h84, d);
    chk("status", d, 32'h0006_0001);
    @(posedge clk);
    #1;
    chk("irq clr", irq, 1'b0);
    cmd(4'hA);
    chk("stop high", tout, 1'b1);
    $display("one-shot test done");
  endtask
  task automatic t_retrig;
    logic [31:0] d;
    logic [15:0] nn;
    int k;
    cmd(4'h4);
    // Normal controls ask for a tristated input; routing must override them.
    pin_tri = 1'b1;
    cmd(4'h7);
    @(posedge clk);
    #1;
    chk("routed", {pin_oe_n, pin}, 32'h1);
    for (nn = 16'd6; nn <= 16'd7; nn++)
    begin
      rd_reg(8'h84, d);
      wr_reg(4'hC, {nn, 16'h0});
      cmd(4'h9);
      wait_lvl(1'b0, k);
      chk("high P", k, nn / 2);
      wait_lvl(1'b1, k);
      chk("low Q", k, nn - nn / 2);
      @(posedge clk);
      #1;
      chk("irq", irq, 1'b1);
      wait_lvl(1'b0, k);
      chk("high P2", k, nn / 2 - 1);
      cmd(4'h8);
      chk("route kept", pin_oe_n, 1'b0);
      cmd(4'hA);
      chk("stop high", tout, 1'b1);
    end
    pin_tri = 1'b0;
    cmd(4'h8);
    @(posedge clk);
    #1;
    chk("unrouted", {pin_oe_n, pin}, 32'h2);
    $display("periodic test done");
  endtask
  task automatic t_ext;
    logic [31:0] d;
    int k;
    // Clear the interrupt left pending by the periodic test.
    rd_reg(8'h84, d);
    cmd(4'h6);
    cmd(4'h3);
    wr_reg(4'hC, 32'h0003_0000);
    cmd(4'h9);
    repeat (30) @(posedge clk);
    #1;
    chk("no ext", tout, 1'b1);
    chk("no ext irq", irq, 1'b0);
    ext_run = 1'b1;
    wait_lvl(1'b0, k);
    ext_run = 1'b0;
    chk("ext len", k >= 16 && k <= 26, 1'b1);
    @(posedge clk);
    #1;
    chk("ext irq", irq, 1'b1);
    cmd(4'hB);
    @(posedge clk);
    #1;
    chk("reset", {tout, pin_oe_n, irq}, 32'h6);
    rd_reg(8'h84, d);
    chk("kept", d, 32'h0003_0000);
    cmd(4'h9);
    wait_lvl(1'b0, k);
    chk("dflt P", k, 1);
    wait_lvl(1'b1, k);
    chk("dflt Q", k, 2);
    @(posedge clk);
    #1;
    chk("int off", irq, 1'b0);
    cmd(4'hA);
    // Enable then disable, and external then internal source, while stopped.
    cmd(4'h1);
    cmd(4'h2);
    cmd(4'h6);
    cmd(4'h5);
    cmd(4'h9);
    wait_lvl(1'b0, k);
    chk("int src P", k, 1);
    wait_lvl(1'b1, k);
    chk("int src Q", k, 2);
    @(posedge clk);
    #1;
    chk("int dis", irq, 1'b0);
    cmd(4'hA);
    $display("external clock test done");
  endtask
  // Main sequence.
  initial
  begin
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_reset;
    t_oneshot;
    t_retrig;
    t_ext;
    test_done;
  end
endmodule
`default_nettype wire
